// ---- data_operation_unit.sv ----
// data operation unit top: wishbone register file, operation sequencing, status and interrupt
`timescale 1ns/10ps
module data_operation_unit
(
	input wire logic clock,
	input wire logic rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [4:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic calc_irq,
	output logic event_link_pulse
);
	typedef struct packed
	{
		logic ack;
		logic [31:0] rdata;
		logic [7:0] calc_control;
		logic [31:0] operand_input;
		logic [31:0] reference_first;
		logic [31:0] reference_second;
		logic [2:0] calc_status;
		logic [2:0] irq_mask;
		logic stopped;
		logic pending;
		logic irq;
		logic event_pulse;
	} unit_state_t;

	unit_state_t st;
	unit_state_t next_st;
	logic access;
	logic wr;
	logic eng_detect;
	logic eng_overflow;
	logic eng_underflow;
	logic [31:0] eng_result;
	logic [2:0] events;
	logic [2:0] clear_bits;
	logic [31:0] rd_mux;

	// byte-lane merge of a bus write into a 32-bit register
	function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				res[i*8 +: 8] = wdat[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// datapath always works from the registered copies, one cycle after the operand write
	calc_engine calc_engine_inst
	(
		.operand(st.operand_input), // RULE9
		.reference_first(st.reference_first), // RULE10
		.reference_second(st.reference_second), // RULE10
		.operand_size_sel(st.calc_control[calc_pkg::CTL_SIZE_BIT]), // RULE1
		.detect_cond_sel(st.calc_control[calc_pkg::CTL_COND_LSB +: 3]), // RULE2
		.mode(st.calc_control[calc_pkg::CTL_MODE_LSB +: 2]),
		.detect(eng_detect),
		.overflow(eng_overflow),
		.underflow(eng_underflow),
		.result(eng_result)
	);

	// one access per request; ack is never given twice in a row, so the master can drop stb
	assign access = cyc_i && stb_i && !st.ack;
	assign wr = access && we_i;

	// read data selection; unmapped and clear-only words read zero
	always_comb
	begin
		case (adr_i)
			calc_pkg::OFS_CONTROL: rd_mux = {24'h000000, st.calc_control};
			calc_pkg::OFS_OPERAND: rd_mux = st.operand_input; // RULE9
			calc_pkg::OFS_REF_FIRST: rd_mux = st.reference_first; // RULE10
			calc_pkg::OFS_REF_SECOND: rd_mux = st.reference_second; // RULE10
			calc_pkg::OFS_STATUS: rd_mux = {29'h0000000, st.calc_status}; // RULE11
			calc_pkg::OFS_IRQ_MASK: rd_mux = {29'h0000000, st.irq_mask};
			calc_pkg::OFS_STOP: rd_mux = {31'h0000000, st.stopped};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// events of the running operation; a frozen unit produces none
	assign events = (st.pending && !st.stopped) ? {eng_underflow, eng_overflow, eng_detect} : 3'h0; // RULE12

	// write-one-to-clear from either the clear word or the status word itself
	assign clear_bits = (wr && sel_i[0] && (adr_i == calc_pkg::OFS_STATUS_CLEAR || adr_i == calc_pkg::OFS_STATUS))
		? dat_i[2:0] : 3'h0; // RULE11

	// next-state logic for the whole unit
	always_comb
	begin
		next_st = st;
		next_st.ack = 1'b0;
		next_st.event_pulse = 1'b0;
		next_st.pending = 1'b0;
		if (access)
		begin
			next_st.ack = 1'b1;
			next_st.rdata = rd_mux;
		end
		// the stop word stays writable so software can wake the unit
		if (wr && adr_i == calc_pkg::OFS_STOP && sel_i[0])
		begin
			next_st.stopped = dat_i[0]; // RULE12
		end
		// every other register is frozen while stopped, as if its clock were halted
		if (wr && !st.stopped)
		begin
			case (adr_i)
				calc_pkg::OFS_CONTROL:
				begin
					if (sel_i[0])
					begin
						next_st.calc_control = dat_i[7:0];
					end
				end
				calc_pkg::OFS_OPERAND:
				begin
					next_st.operand_input = merge_lanes(st.operand_input, dat_i, sel_i); // RULE9
					next_st.pending = 1'b1; // RULE13
				end
				calc_pkg::OFS_REF_FIRST: next_st.reference_first = merge_lanes(st.reference_first, dat_i, sel_i);
				calc_pkg::OFS_REF_SECOND: next_st.reference_second = merge_lanes(st.reference_second, dat_i, sel_i);
				calc_pkg::OFS_IRQ_MASK:
				begin
					if (sel_i[0])
					begin
						next_st.irq_mask = dat_i[2:0];
					end
				end
				default: next_st.pending = 1'b0;
			endcase
		end
		// arithmetic accumulates into the first reference
		if (st.pending && !st.stopped)
		begin
			if (st.calc_control[calc_pkg::CTL_MODE_LSB +: 2] == calc_pkg::OP_ADD
				|| st.calc_control[calc_pkg::CTL_MODE_LSB +: 2] == calc_pkg::OP_SUB)
			begin
				next_st.reference_first = eng_result; // RULE13
			end
		end
		// a set arriving with its clear wins, so no occurrence is lost
		if (!st.stopped)
		begin
			next_st.calc_status = (st.calc_status & ~clear_bits) | events; // RULE11
		end
		next_st.event_pulse = |events; // RULE7
		next_st.irq = next_st.calc_control[calc_pkg::CTL_IEN_BIT] && |(next_st.calc_status & next_st.irq_mask); // RULE8
	end

	// single register stage for all state
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st.ack <= 1'b0;
			st.rdata <= calc_pkg::DATA_RESET;
			st.calc_control <= calc_pkg::CONTROL_RESET;
			st.operand_input <= calc_pkg::DATA_RESET;
			st.reference_first <= calc_pkg::DATA_RESET;
			st.reference_second <= calc_pkg::DATA_RESET;
			st.calc_status <= calc_pkg::STATUS_RESET;
			st.irq_mask <= calc_pkg::MASK_RESET;
			st.stopped <= calc_pkg::STOP_RESET;
			st.pending <= 1'b0;
			st.irq <= 1'b0;
			st.event_pulse <= 1'b0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign dat_o = st.rdata;
	assign ack_o = st.ack;
	assign calc_irq = st.irq;
	assign event_link_pulse = st.event_pulse;

	// checks next to the logic they guard
	logic [32:0] chk_sum32;
	logic [16:0] chk_sum16;
	logic [1:0] chk_mode;
	assign chk_sum32 = {1'b0, st.reference_first} + {1'b0, st.operand_input};
	assign chk_sum16 = {1'b0, st.reference_first[15:0]} + {1'b0, st.operand_input[15:0]};
	assign chk_mode = st.calc_control[calc_pkg::CTL_MODE_LSB +: 2];

	sequence operand_write_s;
		wr && adr_i == calc_pkg::OFS_OPERAND && !st.stopped;
	endsequence

	sequence op_runs_s;
		st.pending && !st.stopped;
	endsequence

	bus_ack_single_a: assert property (@(posedge clock) disable iff (rst)
		access |=> ack_o ##1 !ack_o)
		else $error("ack not a single cycle after request");

	write_starts_op_a: assert property (@(posedge clock) disable iff (rst) // RULE13
		operand_write_s |=> op_runs_s)
		else $error("operand write did not start an operation");

	add_overflow_wide_a: assert property (@(posedge clock) disable iff (rst) // RULE5
		op_runs_s and (chk_mode == calc_pkg::OP_ADD) and st.calc_control[calc_pkg::CTL_SIZE_BIT]
		|=> (st.calc_status[calc_pkg::ST_OVERFLOW] == ($past(st.calc_status[calc_pkg::ST_OVERFLOW])
		&& !$past(clear_bits[calc_pkg::ST_OVERFLOW]) || $past(chk_sum32[32]))) ##1 1'b1)
		else $error("32-bit overflow flag wrong");

	add_narrow_sum_a: assert property (@(posedge clock) disable iff (rst) // RULE1
		op_runs_s and (chk_mode == calc_pkg::OP_ADD) and !st.calc_control[calc_pkg::CTL_SIZE_BIT]
		|=> st.reference_first == {16'h0000, $past(chk_sum16[15:0])} && event_link_pulse == $past(chk_sum16[16]))
		else $error("16-bit add result or overflow event wrong");

	sub_underflow_a: assert property (@(posedge clock) disable iff (rst) // RULE6
		op_runs_s and (chk_mode == calc_pkg::OP_SUB) and st.calc_control[calc_pkg::CTL_SIZE_BIT]
		and (st.operand_input > st.reference_first) |=> st.calc_status[calc_pkg::ST_UNDERFLOW] && event_link_pulse)
		else $error("underflow not flagged");

	match_detect_a: assert property (@(posedge clock) disable iff (rst) // RULE4
		op_runs_s and (chk_mode == calc_pkg::OP_COMPARE) and st.calc_control[calc_pkg::CTL_SIZE_BIT]
		and (st.calc_control[6:4] == calc_pkg::COND_MATCH)
		|=> event_link_pulse == $past(st.operand_input == st.reference_first))
		else $error("match detection wrong");

	event_pulse_short_a: assert property (@(posedge clock) disable iff (rst) // RULE7
		event_link_pulse |=> !event_link_pulse)
		else $error("event pulse longer than one cycle");

	irq_gate_a: assert property (@(posedge clock) disable iff (rst) // RULE8
		!st.calc_control[calc_pkg::CTL_IEN_BIT] |-> !calc_irq)
		else $error("interrupt with enable clear");

	stopped_silent_a: assert property (@(posedge clock) disable iff (rst) // RULE12
		st.stopped && !(wr && adr_i == calc_pkg::OFS_STOP) |=> !event_link_pulse [*2])
		else $error("event while stopped");

	status_clear_a: assert property (@(posedge clock) disable iff (rst) // RULE11
		!st.stopped && clear_bits[calc_pkg::ST_DETECT] && !events[calc_pkg::ST_DETECT]
		|=> !st.calc_status[calc_pkg::ST_DETECT])
		else $error("status bit not cleared");

	operand_readback_a: assert property (@(posedge clock) disable iff (rst) // RULE9
		access && !we_i && adr_i == calc_pkg::OFS_OPERAND |=> ack_o && dat_o == $past(st.operand_input))
		else $error("operand read back wrong");
endmodule

// ---- calc_pkg.sv ----
// constants, register map and field layout of the data operation unit
// Behaviour
// (RULE1) Compare, add and subtract work on 16-bit operands when the size bit is clear and 32-bit when it is set.
// (RULE2) The three-bit condition field in control bits 6..4 picks mismatch, match, less, greater, inside or outside.
// (RULE3) Less and greater test the operand against the first reference; inside and outside use first as low, second as high bound.
// (RULE4) A comparison that meets the selected condition raises the detection indication.
// (RULE5) An addition whose result passes FFFFh (16-bit) or FFFF FFFFh (32-bit) is reported as overflow.
// (RULE6) A subtraction whose result falls below zero at the selected size is reported as underflow.
// (RULE7) The event-link output pulses on detection, overflow and underflow alike.
// (RULE8) Control bit 7 enables the interrupt request; when clear no request is issued.
// (RULE9) The operand input register is a 32-bit readable and writable register feeding each operation.
// (RULE10) Two reference registers, first and second, are readable and writable and serve the comparisons.
// (RULE11) Detected occurrences show in a status register and are cleared by writing the status clear register.
// (RULE12) In module stop the unit is frozen: no operation runs and no event occurs.
// (RULE13) Each operand write starts one operation; add and subtract accumulate into the first reference.
package calc_pkg;

	// word-aligned byte addresses on the register bus
	localparam logic [4:0] OFS_CONTROL = 5'h00;
	localparam logic [4:0] OFS_OPERAND = 5'h04;
	localparam logic [4:0] OFS_REF_FIRST = 5'h08;
	localparam logic [4:0] OFS_REF_SECOND = 5'h0C;
	localparam logic [4:0] OFS_STATUS = 5'h10;
	localparam logic [4:0] OFS_STATUS_CLEAR = 5'h14;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h18;
	localparam logic [4:0] OFS_STOP = 5'h1C;

	// control register fields
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_SIZE_BIT = 3;
	localparam int CTL_COND_LSB = 4;
	localparam int CTL_IEN_BIT = 7;

	// status, clear and mask share this layout
	localparam int ST_DETECT = 0;
	localparam int ST_OVERFLOW = 1;
	localparam int ST_UNDERFLOW = 2;

	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [31:0] DATA_RESET = 32'h00000000;
	localparam logic [2:0] STATUS_RESET = 3'h0;
	localparam logic [2:0] MASK_RESET = 3'h7;
	localparam logic STOP_RESET = 1'b0;

	// operation selected by control bits 1..0
	typedef enum logic [1:0]
	{
		OP_COMPARE = 2'b00,
		OP_ADD = 2'b01,
		OP_SUB = 2'b10,
		OP_NONE = 2'b11
	} op_mode_t;

	// detection conditions, codes 110 and 111 detect nothing
	typedef enum logic [2:0]
	{
		COND_MISMATCH = 3'b000,
		COND_MATCH = 3'b001,
		COND_LESS = 3'b010,
		COND_GREATER = 3'b011,
		COND_INSIDE = 3'b100,
		COND_OUTSIDE = 3'b101
	} detect_cond_t;

endpackage

// ---- calc_engine.sv ----
// combinational compare, add and subtract datapath
`timescale 1ns/10ps
module calc_engine
(
	input wire logic [31:0] operand,
	input wire logic [31:0] reference_first,
	input wire logic [31:0] reference_second,
	input wire logic operand_size_sel,
	input wire logic [2:0] detect_cond_sel,
	input wire logic [1:0] mode,
	output logic detect,
	output logic overflow,
	output logic underflow,
	output logic [31:0] result
);
	logic [31:0] a;
	logic [31:0] r0;
	logic [31:0] r1;
	logic [32:0] sum;
	logic [32:0] diff;
	logic hit;

	// narrow operands lose their upper half so 16-bit mode ignores stale high bits
	assign a = operand_size_sel ? operand : {16'h0000, operand[15:0]}; // RULE1
	assign r0 = operand_size_sel ? reference_first : {16'h0000, reference_first[15:0]}; // RULE1
	assign r1 = operand_size_sel ? reference_second : {16'h0000, reference_second[15:0]}; // RULE1
	assign sum = {1'b0, r0} + {1'b0, a};
	assign diff = {1'b0, r0} - {1'b0, a};

	// condition decode; prohibited codes never detect
	always_comb
	begin
		case (calc_pkg::detect_cond_t'(detect_cond_sel)) // RULE2
			calc_pkg::COND_MISMATCH: hit = (a != r0);
			calc_pkg::COND_MATCH: hit = (a == r0);
			calc_pkg::COND_LESS: hit = (a < r0); // RULE3
			calc_pkg::COND_GREATER: hit = (a > r0); // RULE3
			calc_pkg::COND_INSIDE: hit = (r0 < a) && (a < r1); // RULE3
			calc_pkg::COND_OUTSIDE: hit = (a < r0) || (r1 < a); // RULE3
			default: hit = 1'b0;
		endcase
	end

	// results per operation; the sum is cut to the chosen width
	always_comb
	begin
		detect = 1'b0;
		overflow = 1'b0;
		underflow = 1'b0;
		result = r0;
		case (calc_pkg::op_mode_t'(mode))
			calc_pkg::OP_COMPARE: detect = hit; // RULE4
			calc_pkg::OP_ADD:
			begin
				overflow = operand_size_sel ? sum[32] : sum[16]; // RULE5
				result = operand_size_sel ? sum[31:0] : {16'h0000, sum[15:0]};
			end
			calc_pkg::OP_SUB:
			begin
				underflow = (a > r0); // RULE6
				result = operand_size_sel ? diff[31:0] : {16'h0000, diff[15:0]};
			end
			default: result = r0;
		endcase
	end
endmodule

// ---- data_operation_unit_tb_top.sv ----
// self-checking bench for the data operation unit
`timescale 1ns/10ps
module data_operation_unit_tb_top;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [4:0] adr_i = 5'h00;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h00000000;
	logic [31:0] dat_o;
	logic ack_o;
	logic calc_irq;
	logic event_link_pulse;
	logic [31:0] q;
	int bad_count = 0;
	int tests_run = 0;
	int ev_count = 0;
	int ev_base = 0;

	data_operation_unit data_operation_unit_inst
	(
		.clock(clock),
		.rst(rst),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.sel_i(sel_i),
		.dat_i(dat_i),
		.dat_o(dat_o),
		.ack_o(ack_o),
		.calc_irq(calc_irq),
		.event_link_pulse(event_link_pulse)
	);

	// 25 MHz clock
	always #20 clock = ~clock;

	// one count per sampled high cycle, so a stretched pulse shows as an extra event
	always @(posedge clock)
	begin
		if (event_link_pulse === 1'b1)
			ev_count <= ev_count + 1;
	end

	// verdict and end of run
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// compare and report
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
			bad_count++;
		end
	endtask

	// one classic cycle; ack is sampled at a rising edge and the request is released at that same edge
	task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1)
		begin
			$display("wrong value at %0t: no bus acknowledge", $time);
			bad_count++;
			results();
		end
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask

	task automatic rd(input logic [4:0] a);
		bus(a, 1'b0, 32'h00000000);
	endtask

	// interrupt level once mask or status writes have landed
	task automatic irq_is(input logic e);
		@(negedge clock);
		@(negedge clock);
		check({31'h0000000, calc_irq}, {31'h0000000, e}, "interrupt");
	endtask

	// set up, run one operation and judge status, event count and first reference
	task automatic do_op(input logic [7:0] ctl, input logic [31:0] r0, input logic [31:0] r1,
		input logic [31:0] opnd, input logic [2:0] st, input logic [31:0] exp_r0);
		wr(calc_pkg::OFS_CONTROL, {24'h000000, ctl});
		wr(calc_pkg::OFS_REF_FIRST, r0);
		wr(calc_pkg::OFS_REF_SECOND, r1);
		wr(calc_pkg::OFS_STATUS_CLEAR, 32'h00000007);
		ev_base = ev_count;
		wr(calc_pkg::OFS_OPERAND, opnd);
		rd(calc_pkg::OFS_STATUS);
		check(q, {29'h0000000, st}, "status");
		check(32'(ev_count - ev_base), {31'h0000000, st != 3'h0}, "event count");
		rd(calc_pkg::OFS_REF_FIRST);
		check(q, exp_r0, "first reference");
	endtask

	// reset values of every word, mask comes up all ones
	task automatic reset_values();
		logic [31:0] exp [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h7, 32'h0};
		for (int i = 0; i < 8; i++)
		begin
			rd(5'(i * 4));
			check(q, exp[i], "reset value");
		end
	endtask

	// data registers hold full 32-bit patterns
	task automatic reg_access();
		wr(calc_pkg::OFS_REF_FIRST, 32'h12345678);
		wr(calc_pkg::OFS_REF_SECOND, 32'h89ABCDEF);
		wr(calc_pkg::OFS_OPERAND, 32'hA5A55A5A);
		rd(calc_pkg::OFS_OPERAND);
		check(q, 32'hA5A55A5A, "operand");
		rd(calc_pkg::OFS_REF_FIRST);
		check(q, 32'h12345678, "first reference");
		rd(calc_pkg::OFS_REF_SECOND);
		check(q, 32'h89ABCDEF, "second reference");
		// only the two low byte lanes are enabled, the upper half must survive
		sel_i <= 4'h3;
		wr(calc_pkg::OFS_REF_SECOND, 32'h00001111);
		sel_i <= 4'hF;
		rd(calc_pkg::OFS_REF_SECOND);
		check(q, 32'h89AB1111, "byte lanes");
	endtask

	// every condition code against inside, on the low bound and above the bounds 3 and 9
	task automatic compare_conds();
		logic [31:0] opnd [3] = '{32'h5, 32'h3, 32'hA};
		logic [7:0] hit [3] = '{8'h19, 8'h02, 8'h29};
		for (int k = 0; k < 3; k++)
			for (int c = 0; c < 8; c++)
				do_op({1'b0, 3'(c), 4'h8}, 32'h3, 32'h9, opnd[k], {2'b00, hit[k][c]}, 32'h3);
		do_op(8'h10, 32'h3, 32'h9, 32'h00010003, 3'h1, 32'h3);
		do_op(8'h18, 32'h3, 32'h9, 32'h00010003, 3'h0, 32'h3);
	endtask

	// carries and borrows at both sizes, plus accumulation
	task automatic arith();
		do_op(8'h01, 32'h0000FFFF, 32'h0, 32'h00000002, 3'h2, 32'h00000001);
		do_op(8'h01, 32'h00001000, 32'h0, 32'h00000234, 3'h0, 32'h00001234);
		wr(calc_pkg::OFS_OPERAND, 32'h00000010);
		rd(calc_pkg::OFS_REF_FIRST);
		check(q, 32'h00001244, "accumulate");
		do_op(8'h09, 32'hFFFFFFFF, 32'h0, 32'h00000001, 3'h2, 32'h00000000);
		do_op(8'h09, 32'h0000FFFF, 32'h0, 32'h00000002, 3'h0, 32'h00010001);
		do_op(8'h02, 32'h00000001, 32'h0, 32'h00000002, 3'h4, 32'h0000FFFF);
		do_op(8'h0A, 32'h00000005, 32'h0, 32'h00000005, 3'h0, 32'h00000000);
		do_op(8'h0A, 32'h00000000, 32'h0, 32'h00000001, 3'h4, 32'hFFFFFFFF);
		do_op(8'h0B, 32'h00000005, 32'h0, 32'h00000001, 3'h0, 32'h00000005);
	endtask

	// enable, mask and clear paths of the interrupt
	task automatic irq_path();
		do_op(8'h98, 32'h3, 32'h0, 32'h3, 3'h1, 32'h3);
		irq_is(1'b1);
		wr(calc_pkg::OFS_IRQ_MASK, 32'h0);
		irq_is(1'b0);
		wr(calc_pkg::OFS_IRQ_MASK, 32'h7);
		irq_is(1'b1);
		wr(calc_pkg::OFS_STATUS_CLEAR, 32'h1);
		irq_is(1'b0);
		rd(calc_pkg::OFS_STATUS);
		check(q, 32'h0, "cleared status");
		do_op(8'h18, 32'h3, 32'h0, 32'h3, 3'h1, 32'h3);
		irq_is(1'b0);
	endtask

	// stopped unit ignores operand and reference writes and raises nothing; the operand would overflow if it ran
	task automatic stop_mode();
		do_op(8'h09, 32'hFFFFFFFF, 32'h0, 32'h0, 3'h0, 32'hFFFFFFFF);
		wr(calc_pkg::OFS_STOP, 32'h1);
		ev_base = ev_count;
		wr(calc_pkg::OFS_OPERAND, 32'h1);
		wr(calc_pkg::OFS_REF_FIRST, 32'h55);
		rd(calc_pkg::OFS_REF_FIRST);
		check(q, 32'hFFFFFFFF, "frozen reference");
		rd(calc_pkg::OFS_OPERAND);
		check(q, 32'h0, "frozen operand");
		rd(calc_pkg::OFS_STATUS);
		check(q, 32'h0, "status while stopped");
		check(32'(ev_count - ev_base), 32'h0, "event while stopped");
		wr(calc_pkg::OFS_STOP, 32'h0);
		wr(calc_pkg::OFS_OPERAND, 32'h1);
		rd(calc_pkg::OFS_STATUS);
		check(q, 32'h2, "status after wake");
	endtask

	// main sequence
	initial
	begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		reset_values();
		reg_access();
		compare_conds();
		arith();
		irq_path();
		stop_mode();
		results();
	end
endmodule
